// ---- core/lcdctl_core.sv ----
// Segment LCD control block: control/prescale/segment/pixel state, frame timing, frame flag.
// Assumes oscillator ticks arrive as asynchronous levels; software ports are on clk_sys.
//
// Functional notes
// - The selected clock source is divided by the 4-bit frame prescale plus one.
// - A set segment-enable bit makes its pin a segment driver instead of its alternate use.
// - The 2-bit mux select picks the multiplex and bias mode for common and segment waves.
// - The 2-bit clock select picks which oscillator feeds frame timing.
// - The sleep bit decides whether the block keeps running in sleep.
// - Pixel data registers, 12 or 24 of them, hold one bit per pixel and are software writable.
// - The frame flag and its enable live in peripheral registers two; software clears the flag first.
// - The bias-pin enable connects the three bias voltage pins to the driver.
// - Writing all zeros to the control register stops timing, commons, segment drive and bias; segment pins keep output enable.
// - The source is system clock over 8192, or timer1 or low-frequency oscillator over 32.
// - In quarter mux the frame rate is the source over four times prescale plus one.
// - On reset the mux select is binary 11, quarter multiplex.
// - A set segment-enable bit overrides the pin's data direction.
`timescale 1ns/1ps
`include "lcdctl_defines.svh"
module lcdctl_core #(
    parameter int unsigned SEG_PINS   = 24,
    parameter int unsigned PIXEL_REGS = 12,
    parameter int unsigned SYS_DIV    = `LCDCTL_SYS_DIV
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  sleep_mode,
    input  wire logic                  timer1_osc,
    input  wire logic                  low_freq_internal_osc,
    input  wire logic                  ctrl_we,
    input  wire logic [7:0]            ctrl_wdata,
    input  wire logic                  prescale_we,
    input  wire logic [3:0]            prescale_wdata,
    input  wire logic                  segen_we,
    input  wire logic [SEG_PINS-1:0]   segen_wdata,
    input  wire logic                  pixel_we,
    input  wire logic [$clog2(PIXEL_REGS)-1:0] pixel_addr,
    input  wire logic [7:0]            pixel_wdata,
    input  wire logic                  flag_clear,
    input  wire logic                  irq_enable_we,
    input  wire logic                  irq_enable_wdata,
    input  wire logic [SEG_PINS-1:0]   pin_dir_out,
    output logic [7:0]                 lcd_control_reg,
    output logic [3:0]                 frame_prescale_reg,
    output logic [SEG_PINS-1:0]        segment_enable_regs,
    output logic [7:0]                 pixel_rdata,
    output logic                       frame_irq_flag,
    output logic                       frame_irq_enable,
    output logic                       frame_irq,
    output logic [SEG_PINS-1:0]        segment_drive,
    output logic [SEG_PINS-1:0]        pin_oe_final,
    output logic [3:0]                 com_active,
    output logic [1:0]                 frame_phase,
    output logic                       frame_tick,
    output logic                       bias_voltage_pins_en,
    output logic                       running
);
    // -------------------------------------------------------------------------
    // Control state
    // -------------------------------------------------------------------------
    logic [7:0] pixel_mem_reg [PIXEL_REGS];
    logic       module_enable;
    logic       sleep_run_enable;
    logic       bias_pin_enable;
    lcdctl_pkg::lcdctl_mux_t mux_select;
    lcdctl_pkg::lcdctl_src_t clk_select;

    assign module_enable    = lcd_control_reg[`LCDCTL_CON_EN_BIT];
    assign sleep_run_enable = lcd_control_reg[`LCDCTL_CON_SLEEP_BIT];
    assign bias_pin_enable  = lcd_control_reg[`LCDCTL_CON_BIAS_BIT];
    assign mux_select = lcdctl_pkg::lcdctl_mux_t'(lcd_control_reg[`LCDCTL_CON_MUX_LSB +: 2]);
    assign clk_select = lcdctl_pkg::lcdctl_src_t'(lcd_control_reg[`LCDCTL_CON_CS_LSB +: 2]);

    // Writing all zeros clears the enable too, so the module stops at once.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            lcd_control_reg <= `LCDCTL_CON_RESET;
        end else if (ctrl_we) begin
            lcd_control_reg <= ctrl_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            frame_prescale_reg <= `LCDCTL_PS_RESET;
        end else if (prescale_we) begin
            frame_prescale_reg <= prescale_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            segment_enable_regs <= '0;
        end else if (segen_we) begin
            segment_enable_regs <= segen_wdata;
        end
    end

    // Pixel bits are plain storage; unused ones serve as spare RAM.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < PIXEL_REGS; i++) begin
                pixel_mem_reg[i] <= 8'h00;
            end
        end else if (pixel_we && (int'(pixel_addr) < PIXEL_REGS)) begin
            pixel_mem_reg[pixel_addr] <= pixel_wdata;
        end
    end

    assign pixel_rdata = (int'(pixel_addr) < PIXEL_REGS) ? pixel_mem_reg[pixel_addr] : 8'h00;

    // -------------------------------------------------------------------------
    // Oscillator synchronisers and edge detection
    // -------------------------------------------------------------------------
    logic [2:0] t1_sync_reg;
    logic [2:0] lf_sync_reg;
    logic       t1_rise;
    logic       lf_rise;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            t1_sync_reg <= 3'h0;
            lf_sync_reg <= 3'h0;
        end else begin
            t1_sync_reg <= {t1_sync_reg[1:0], timer1_osc};
            lf_sync_reg <= {lf_sync_reg[1:0], low_freq_internal_osc};
        end
    end

    // Edges are taken between the second and third stages only.
    assign t1_rise = t1_sync_reg[1] & ~t1_sync_reg[2];
    assign lf_rise = lf_sync_reg[1] & ~lf_sync_reg[2];

    // -------------------------------------------------------------------------
    // Source selection and dividers
    // -------------------------------------------------------------------------
    logic src_tick;
    logic src_div_tick;
    logic slow_tick;
    logic sys_div_tick;
    logic use_sys;

    // In sleep every source halts unless the sleep bit is set; a system source is treated no differently.
    assign running = module_enable && (!sleep_mode || sleep_run_enable);
    assign use_sys = (clk_select == lcdctl_pkg::LCDCTL_CS_SYS);

    always_comb begin
        unique case (clk_select)
            lcdctl_pkg::LCDCTL_CS_SYS:    src_tick = 1'b1;
            lcdctl_pkg::LCDCTL_CS_TIMER1: src_tick = t1_rise;
            default:                      src_tick = lf_rise;
        endcase
    end

    // One divider serves both source rates; its limit follows the source.
    lcdctl_tick_div #(
        .DIV (SYS_DIV),
        .W   (14)
    ) u_src_div (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .clear     (!running),
        .tick_in   (src_tick),
        .limit     (use_sys ? 14'(SYS_DIV - 1) : 14'(`LCDCTL_SLOW_DIV - 1)),
        .use_limit (1'b1),
        .tick_out  (src_div_tick)
    );
    assign slow_tick    = src_div_tick;
    assign sys_div_tick = src_div_tick;

    // Prescale stage: source over (prescale + 1) gives one phase tick.
    logic       phase_tick;
    logic [3:0] ps_count_reg;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !running) begin
            ps_count_reg <= 4'h0;
            phase_tick   <= 1'b0;
        end else begin
            phase_tick <= 1'b0;
            if (slow_tick || sys_div_tick) begin
                if (ps_count_reg >= frame_prescale_reg) begin
                    ps_count_reg <= 4'h0;
                    phase_tick   <= 1'b1;
                end else begin
                    ps_count_reg <= ps_count_reg + 4'h1;
                end
            end
        end
    end

    // -------------------------------------------------------------------------
    // Frame phase: four phase ticks per frame in every mode
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !running) begin
            frame_phase <= 2'h0;
            frame_tick  <= 1'b0;
        end else begin
            frame_tick <= 1'b0;
            if (phase_tick) begin
                frame_phase <= frame_phase + 2'h1;
                frame_tick  <= (frame_phase == 2'(`LCDCTL_PHASES_PER_FRAME - 1));
            end
        end
    end

    // -------------------------------------------------------------------------
    // Frame flag and enable
    // -------------------------------------------------------------------------
    // A frame event in the clear cycle wins, so no boundary is lost.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            frame_irq_flag <= 1'b0;
        end else if (frame_tick && module_enable) begin
            frame_irq_flag <= 1'b1;
        end else if (flag_clear) begin
            frame_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            frame_irq_enable <= 1'b0;
        end else if (irq_enable_we) begin
            frame_irq_enable <= irq_enable_wdata;
        end
    end

    assign frame_irq = frame_irq_flag & frame_irq_enable;

    // -------------------------------------------------------------------------
    // Pin ownership and common selection
    // -------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bias_voltage_pins_en <= 1'b0;
            segment_drive        <= '0;
            pin_oe_final         <= '0;
            com_active           <= 4'h0;
        end else begin
            bias_voltage_pins_en <= bias_pin_enable && module_enable;
            segment_drive        <= module_enable ? segment_enable_regs : '0;
            // Segment pins always drive; other pins follow their direction bit.
            pin_oe_final         <= segment_enable_regs | pin_dir_out;
            if (!running) begin
                com_active <= 4'h0;
            end else begin
                unique case (mux_select)
                    lcdctl_pkg::LCDCTL_MUX_STATIC:  com_active <= 4'h1;
                    lcdctl_pkg::LCDCTL_MUX_HALF:    com_active <= 4'h3;
                    lcdctl_pkg::LCDCTL_MUX_THIRD:   com_active <= 4'h7;
                    lcdctl_pkg::LCDCTL_MUX_QUARTER: com_active <= 4'hF;
                endcase
            end
        end
    end
endmodule

// ---- core/lcdctl_defines.svh ----
// Constants for the segment LCD control block: field positions, reset values, divider counts.
// Assumes inclusion by bare name from core files only.
`ifndef LCDCTL_DEFINES_SVH
`define LCDCTL_DEFINES_SVH

// -----------------------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------------------
`define LCDCTL_CON_MUX_LSB      0
`define LCDCTL_CON_CS_LSB       2
`define LCDCTL_CON_BIAS_BIT     4
`define LCDCTL_CON_SLEEP_BIT    6
`define LCDCTL_CON_EN_BIT       7
`define LCDCTL_CON_RESET        8'h13
`define LCDCTL_PS_RESET         4'h0

// -----------------------------------------------------------------------------
// Source pre-dividers
// -----------------------------------------------------------------------------
`define LCDCTL_SYS_DIV          8192
`define LCDCTL_SLOW_DIV         32
`define LCDCTL_PHASES_PER_FRAME 4

`endif

// ---- core/lcdctl_pkg.sv ----
// Types shared by the segment LCD control block.
// Assumes nothing outside itself.
package lcdctl_pkg;
    typedef enum logic [1:0] {
        LCDCTL_MUX_STATIC,
        LCDCTL_MUX_HALF,
        LCDCTL_MUX_THIRD,
        LCDCTL_MUX_QUARTER
    } lcdctl_mux_t;

    typedef enum logic [1:0] {
        LCDCTL_CS_SYS,
        LCDCTL_CS_TIMER1,
        LCDCTL_CS_LFINT,
        LCDCTL_CS_LFINT_ALT
    } lcdctl_src_t;
endpackage

// ---- core/lcdctl_tick_div.sv ----
// Tick divider: emits one-cycle pulse every DIV (or limit plus one when use_limit is set) qualified input ticks.
// Assumes tick_in is already in the clk_sys domain.
`timescale 1ns/1ps
module lcdctl_tick_div #(
    parameter int unsigned DIV = 32,
    parameter int unsigned W   = 13
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         clear,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] limit,
    input  wire logic         use_limit,
    output logic              tick_out
);
    logic [W-1:0] count_reg;
    logic [W-1:0] top;

    assign top = use_limit ? limit : W'(DIV - 1);

    always_ff @(posedge clk_sys) begin
        if (!rst_n || clear) begin
            count_reg <= '0;
            tick_out  <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (count_reg >= top) begin
                    count_reg <= '0;
                    tick_out  <= 1'b1;
                end else begin
                    count_reg <= count_reg + W'(1);
                end
            end
        end
    end
endmodule

// ---- sim/lcdctl_monitor.sv ----
// Checker for the port behaviour of the segment LCD control block.
// Assumes it is bound to lcdctl_core and sees only its ports.
`timescale 1ns/1ps
module lcdctl_monitor #(
    parameter int unsigned SEG_PINS = 24
) (
    input wire logic                clk_sys,
    input wire logic                rst_n,
    input wire logic                sleep_mode,
    input wire logic                ctrl_we,
    input wire logic [7:0]          ctrl_wdata,
    input wire logic                flag_clear,
    input wire logic [SEG_PINS-1:0] pin_dir_out,
    input wire logic [7:0]          lcd_control_reg,
    input wire logic [SEG_PINS-1:0] segment_enable_regs,
    input wire logic                frame_irq_flag,
    input wire logic                frame_irq_enable,
    input wire logic                frame_irq,
    input wire logic [SEG_PINS-1:0] segment_drive,
    input wire logic [SEG_PINS-1:0] pin_oe_final,
    input wire logic [3:0]          com_active,
    input wire logic                frame_tick
);
    // -------------------------------------------------------------------------
    // Properties
    // -------------------------------------------------------------------------
    logic [3:0] com_exp;
    assign com_exp = 4'hF >> (2'h3 - lcd_control_reg[1:0]);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // Registered outputs lag their sources by one edge, so only judge settled inputs.
    sequence s_steady;
        $past(rst_n) && $stable(lcd_control_reg) && $stable(segment_enable_regs) && $stable(sleep_mode);
    endsequence
    sequence s_off3;
        !lcd_control_reg[7] [*3];
    endsequence
    sequence s_flag_next;
        ##1 frame_irq_flag;
    endsequence

    a_ctrl_load: assert property (ctrl_we |=> lcd_control_reg == $past(ctrl_wdata))
        else $error("control readback differs from written value");
    a_flag_set: assert property (frame_tick && lcd_control_reg[7] |-> s_flag_next)
        else $error("frame flag not set after frame boundary");
    a_tick_single: assert property (frame_tick |=> !frame_tick)
        else $error("frame boundary pulse longer than one cycle");
    a_flag_clear: assert property (flag_clear && !frame_tick |=> !frame_irq_flag)
        else $error("frame flag survived a clear");
    a_irq_gate: assert property (frame_irq == (frame_irq_flag && frame_irq_enable))
        else $error("interrupt output not flag and enable");
    a_idle_quiet: assert property (s_off3 |-> !frame_tick && com_active == 4'h0 && segment_drive == '0)
        else $error("activity while module disabled");
    a_seg_gate: assert property (s_steady ##0 !sleep_mode |->
        segment_drive == (segment_enable_regs & {SEG_PINS{lcd_control_reg[7]}}))
        else $error("segment drive not enables gated by module enable");
    a_pin_override: assert property (s_steady ##0 $stable(pin_dir_out) |->
        pin_oe_final == (segment_enable_regs | pin_dir_out))
        else $error("segment enable did not override direction");
    a_com_mux: assert property (s_steady ##0 lcd_control_reg[7] && !sleep_mode |-> com_active == com_exp)
        else $error("commons in use do not match mux select");
endmodule

bind lcdctl_core lcdctl_monitor #(.SEG_PINS(SEG_PINS)) u_mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .sleep_mode(sleep_mode), .ctrl_we(ctrl_we),
    .ctrl_wdata(ctrl_wdata), .flag_clear(flag_clear), .pin_dir_out(pin_dir_out),
    .lcd_control_reg(lcd_control_reg), .segment_enable_regs(segment_enable_regs),
    .frame_irq_flag(frame_irq_flag), .frame_irq_enable(frame_irq_enable), .frame_irq(frame_irq),
    .segment_drive(segment_drive), .pin_oe_final(pin_oe_final), .com_active(com_active),
    .frame_tick(frame_tick));

// ---- sim/lcdctl_glass.sv ----
// Model of the LCD glass: counts frames that actually reach the electrodes.
// Assumes commons and segments come straight from lcdctl_core.
`timescale 1ns/1ps
module lcdctl_glass #(
    parameter int unsigned SEG_PINS = 24
) (
    input wire logic                clk_sys,
    input wire logic [3:0]          com_active,
    input wire logic [SEG_PINS-1:0] segment_drive,
    input wire logic                frame_tick,
    output int                      frames_lit
);
    // A pixel only darkens when a common and a segment are both driven.
    initial frames_lit = 0;
    always @(posedge clk_sys) begin
        if (frame_tick && com_active != 4'h0 && segment_drive != '0) begin
            frames_lit <= frames_lit + 1;
        end
    end
endmodule

// ---- sim/lcdctl_core_tb_top.sv ----
// Testbench for lcdctl_core: setup order, frame timing, sources, sleep and disable.
// Assumes the glass model and the bound checker are compiled with it.
`timescale 1ns/1ps
module lcdctl_core_tb_top;
    // -------------------------------------------------------------------------
    // Signals and instances
    // -------------------------------------------------------------------------
    localparam int SYSD = 16;
    logic        clk_sys, rst_n, sleep_mode, timer1_osc, low_freq_internal_osc, ctrl_we, prescale_we;
    logic        segen_we, pixel_we, flag_clear, irq_enable_we, irq_enable_wdata;
    logic [3:0]  prescale_wdata, pixel_addr, frame_prescale_reg, com_active;
    logic [1:0]  frame_phase;
    logic        running;
    logic [7:0]  ctrl_wdata, pixel_wdata, lcd_control_reg, pixel_rdata;
    logic [23:0] segen_wdata, pin_dir_out, segment_enable_regs, segment_drive, pin_oe_final;
    logic        frame_irq_flag, frame_irq_enable, frame_irq, frame_tick, bias_voltage_pins_en;
    int          err_count = 0, checks_done = 0, frames_lit, n;

    lcdctl_core #(.SEG_PINS(24), .PIXEL_REGS(12), .SYS_DIV(SYSD)) DUT (.clk_sys, .rst_n, .sleep_mode,
        .timer1_osc, .low_freq_internal_osc, .ctrl_we, .ctrl_wdata, .prescale_we, .prescale_wdata,
        .segen_we, .segen_wdata, .pixel_we, .pixel_addr, .pixel_wdata, .flag_clear, .irq_enable_we,
        .irq_enable_wdata, .pin_dir_out, .lcd_control_reg, .frame_prescale_reg, .segment_enable_regs,
        .pixel_rdata, .frame_irq_flag, .frame_irq_enable, .frame_irq, .segment_drive, .pin_oe_final,
        .com_active, .frame_phase, .frame_tick, .bias_voltage_pins_en, .running);
    lcdctl_glass #(.SEG_PINS(24)) u_glass (.clk_sys, .com_active, .segment_drive, .frame_tick, .frames_lit);

    // Oscillator edges land on falling clock edges, so frame lengths are exact.
    always #12.5 clk_sys = ~clk_sys;
    always #50 timer1_osc = ~timer1_osc;
    always #75 low_freq_internal_osc = ~low_freq_internal_osc;

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wr_ctrl(input logic [7:0] v);
        @(negedge clk_sys);
        ctrl_we = 1'b1;
        ctrl_wdata = v;
        @(negedge clk_sys);
        ctrl_we = 1'b0;
    endtask
    task automatic wr_ps(input logic [3:0] v);
        @(negedge clk_sys);
        prescale_we = 1'b1;
        prescale_wdata = v;
        @(negedge clk_sys);
        prescale_we = 1'b0;
    endtask
    task automatic wr_pix(input logic [3:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        pixel_we = 1'b1;
        pixel_addr = a;
        pixel_wdata = v;
        @(negedge clk_sys);
        pixel_we = 1'b0;
    endtask
    task automatic wait_tick(output int k);
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (frame_tick !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            err_count++;
            results();
        end
    endtask
    task automatic count_ticks(input int cyc, output int k);
        k = 0;
        repeat (cyc) begin
            @(negedge clk_sys);
            if (frame_tick === 1'b1) k++;
        end
    endtask

    // -------------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------------
    task automatic t_setup;
        chk("reset control", 8'h13, lcd_control_reg);
        chk("reset segen", 24'h00_0000, segment_enable_regs);
        wr_ps(4'h1);
        @(negedge clk_sys);
        segen_we = 1'b1;
        segen_wdata = 24'hA5_00FF;
        @(negedge clk_sys);
        segen_we = 1'b0;
        wr_ctrl(8'h03);
        wr_pix(4'h0, 8'h3C);
        wr_pix(4'hB, 8'hC3);
        wr_pix(4'hC, 8'hFF);
        @(negedge clk_sys);
        flag_clear = 1'b1;
        irq_enable_we = 1'b1;
        irq_enable_wdata = 1'b1;
        @(negedge clk_sys);
        flag_clear = 1'b0;
        irq_enable_we = 1'b0;
        wr_ctrl(8'h13);
        wr_ctrl(8'h93);
        @(negedge clk_sys);
        chk("prescale", 4'h1, frame_prescale_reg);
        chk("control", 8'h93, lcd_control_reg);
        chk("bias", 1'b1, bias_voltage_pins_en);
        chk("irq enable", 1'b1, frame_irq_enable);
        chk("pin oe", 24'hA5_0FFF, pin_oe_final);
        pixel_addr = 4'hB;
        #1 chk("pixel 11", 8'hC3, pixel_rdata);
        pixel_addr = 4'h4;
        #1 chk("pixel 4", 8'h00, pixel_rdata);
    endtask
    task automatic t_frame;
        int p[3] = '{0, 1, 15};
        foreach (p[i]) begin
            wr_ps(p[i][3:0]);
            wait_tick(n);
            wait_tick(n);
            chk("frame cycles", SYSD * 4 * (p[i] + 1), n);
        end
        @(negedge clk_sys);
        chk("flag", 1'b1, frame_irq_flag);
        chk("irq", 1'b1, frame_irq);
        flag_clear = 1'b1;
        @(negedge clk_sys);
        flag_clear = 1'b0;
        chk("flag cleared", 1'b0, frame_irq_flag);
        chk("glass frames", 1'b1, frames_lit > 0);
    endtask
    task automatic t_sources;
        wr_ps(4'h0);
        for (int cs = 1; cs < 4; cs++) begin
            wr_ctrl(8'h93 | {4'h0, cs[1:0], 2'h0});
            wait_tick(n);
            wait_tick(n);
            chk("source cycles", 32 * 4 * (cs == 1 ? 4 : 6), n);
        end
    endtask
    task automatic t_sleep;
        wr_ctrl(8'h8F);
        sleep_mode = 1'b1;
        count_ticks(1600, n);
        chk("sleep ticks", 0, n);
        chk("sleep running", 1'b0, running);
        wr_ctrl(8'hCF);
        wait_tick(n);
        wait_tick(n);
        chk("sleep run cycles", 768, n);
        chk("sleep run", 1'b1, running);
        sleep_mode = 1'b0;
    endtask
    task automatic t_mux;
        for (int m = 0; m < 4; m++) begin
            wr_ctrl({6'h20, m[1:0]});
            repeat (2) @(negedge clk_sys);
            chk("commons", 4'hF >> (3 - m), com_active);
        end
    endtask
    task automatic t_disable;
        wr_ctrl(8'h00);
        flag_clear = 1'b1;
        @(negedge clk_sys);
        flag_clear = 1'b0;
        count_ticks(1100, n);
        chk("off ticks", 0, n);
        chk("off flag", 1'b0, frame_irq_flag);
        chk("off segments", 24'h00_0000, segment_drive);
        chk("off bias", 1'b0, bias_voltage_pins_en);
        chk("off phase", 2'h0, frame_phase);
        chk("off running", 1'b0, running);
    endtask

    initial begin
        {clk_sys, rst_n, sleep_mode, timer1_osc, low_freq_internal_osc, ctrl_we, prescale_we} = '0;
        {segen_we, pixel_we, flag_clear, irq_enable_we, irq_enable_wdata} = '0;
        {prescale_wdata, pixel_addr, ctrl_wdata, pixel_wdata, segen_wdata} = '0;
        pin_dir_out = 24'h00_0F0F;
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        t_setup();
        t_frame();
        t_sources();
        t_sleep();
        t_mux();
        t_disable();
        results();
    end
endmodule
